//--- logic/match_timer.sv
`timescale 1ns/1ps
`default_nettype none
module match_timer #(
  parameter int MATCH_COUNT = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  output logic match
);
  localparam int CW = $clog2(MATCH_COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(MATCH_COUNT - 1);

  logic [CW-1:0] count_ff;

  // a stopped channel restarts a full interval when started again
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      count_ff <= '0;
    end else if (tick) begin
      if (count_ff == LAST) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff + 1'b1;
      end
    end
  end

  assign match = run && tick && (count_ff == LAST);

  a_match_at_last: assert property (@(posedge clk) disable iff (srst)
    match |=> (count_ff == '0))
    else $error("timer did not wrap after match");
endmodule // match_timer
`default_nettype wire

//--- logic/pattern_pkg.sv
`default_nettype none
package pattern_pkg;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int PRESCALE = 512;
  localparam int PERIOD0_MS = 500;
  localparam int PERIOD3_MS = 250;
  // compare counts in prescaled ticks, rounded down
  localparam int MATCH0_COUNT = (CLK_HZ / 1000) * PERIOD0_MS / PRESCALE;
  localparam int MATCH3_COUNT = (CLK_HZ / 1000) * PERIOD3_MS / PRESCALE;

  // transfer descriptors
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] REPEAT0 = 4'h4;
  localparam logic [CNT_W-1:0] REPEAT3 = 4'h8;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;
  localparam int ROM_AW = 4;
  localparam int ROM_DEPTH = 16;
  localparam logic [31:0] LED_SRC_BASE = 32'h0000_1000;
  localparam logic [31:0] PAT_SRC_BASE = 32'h0000_1008;
  localparam logic [31:0] LED_PORT_ADDR = 32'h0008_0001;
  localparam logic [31:0] PAT_PORT_ADDR = 32'h0008_000a;

  // port values, led nibble is active low
  localparam logic [7:0] LED_ALL_OFF = 8'hf0;
  localparam logic [7:0] LED0_ON = 8'he0;
  localparam logic [7:0] LED1_ON = 8'hd0;
  localparam logic [7:0] LED2_ON = 8'hb0;
  localparam logic [7:0] LED3_ON = 8'h70;
  localparam logic [7:0] PAT_RESET = 8'h00;
  localparam logic [7:0] PAT_FIRST = 8'h01;
  localparam logic [7:0] ROM_INIT [ROM_DEPTH] = '{
    LED0_ON, LED1_ON, LED2_ON, LED3_ON, 8'h00, 8'h00, 8'h00, 8'h00,
    PAT_FIRST, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SAR0 = 8'h08;
  localparam logic [7:0] REG_SAR3 = 8'h0c;
  localparam logic [7:0] REG_DAR0 = 8'h10;
  localparam logic [7:0] REG_DAR3 = 8'h14;
  localparam logic [7:0] REG_PORTS = 8'h18;
  localparam int CTRL_START0 = 0;
  localparam int CTRL_START3 = 1;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_READ = 2'b01,
    XS_WRITE = 2'b11
  } xfer_state_e;
endpackage
`default_nettype wire

//--- logic/pattern_rom.sv
`timescale 1ns/1ps
`default_nettype none
module pattern_rom #(
  parameter int AW = pattern_pkg::ROM_AW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [AW-1:0] addr,
  output logic [7:0] rdata
);
  // registered read: data stands one cycle after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= pattern_pkg::ROM_INIT[addr];
    end
  end
endmodule // pattern_rom
`default_nettype wire

//--- logic/timer_paced_pattern_transfer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - channel 0 matches every 500 ms, prescale 512
// - channel 3 matches every 250 ms
// - start bits set to 1 begin counting
// - only timer matches start transfers
// - descriptors hold full 32-bit addresses
// - source address increments after each byte except the last of a round, which reloads the base
// - destination address never changes
// - each activation moves exactly one byte
// - channel 0 repeats after 4 transfers
// - channel 3 repeats after 8 transfers
// - channel 0 writes the led port
// - channel 3 writes the pattern port
// - first channel 3 byte is 01h
// - channel 3 restarts at first table byte
// - channel 0 restarts at first table byte
// - led port bits 4-7 drive four leds
// - led transfers drive bits 0-3 low
// - led nibble active low, F0h all off
module timer_paced_pattern_transfer #(
  parameter int PRESCALE = pattern_pkg::PRESCALE,
  parameter int MATCH0_COUNT = pattern_pkg::MATCH0_COUNT,
  parameter int MATCH3_COUNT = pattern_pkg::MATCH3_COUNT
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic [7:0] LED_PORT,
  output logic [7:0] PATTERN_PINS
);
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);
  localparam int CW = pattern_pkg::CNT_W;
  localparam logic [31:0] SRC_BASE [2] = '{
    pattern_pkg::LED_SRC_BASE, pattern_pkg::PAT_SRC_BASE};
  localparam logic [31:0] DEST [2] = '{
    pattern_pkg::LED_PORT_ADDR, pattern_pkg::PAT_PORT_ADDR};
  localparam logic [CW-1:0] REPEAT [2] = '{
    pattern_pkg::REPEAT0, pattern_pkg::REPEAT3};

  logic [PW-1:0] presc_ff;
  logic tick;
  logic [1:0] ctrl_ff;
  logic match [2];
  logic pend_ff [2];
  logic grant [2];
  pattern_pkg::xfer_state_e state_ff;
  pattern_pkg::xfer_state_e nxt_state;
  logic chan_ff;
  logic nxt_chan;
  logic [31:0] source_address_reg_ff [2];
  logic [31:0] dest_address_reg_ff [2];
  logic [CW-1:0] count_ff [2];
  logic [7:0] rom_data;
  logic [7:0] led_port_ff;
  logic [7:0] pattern_port_ff;
  logic [31:0] rdata_ff;
  logic last_xfer;

  // shared prescaler for both channels
  always_ff @(posedge CLK) begin
    if (SRST) begin
      presc_ff <= '0;
    end else if (presc_ff == PRESC_LAST) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end
  assign tick = (presc_ff == PRESC_LAST);

  // start bits, written by software
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_ff <= 2'h0;
    end else if (WR && ADDR == pattern_pkg::REG_CTRL) begin
      ctrl_ff <= WDATA[1:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      match_timer #(
        .MATCH_COUNT(c == 0 ? MATCH0_COUNT : MATCH3_COUNT)
      ) u_timer (
        .clk(CLK),
        .srst(SRST),
        .run(ctrl_ff[c]),
        .tick(tick),
        .match(match[c])
      );
      // a request that lands on its own grant cycle stays pending
      always_ff @(posedge CLK) begin
        if (SRST) begin
          pend_ff[c] <= 1'b0;
        end else if (match[c]) begin
          pend_ff[c] <= 1'b1;
        end else if (grant[c]) begin
          pend_ff[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // channel 0 first; channel 3 follows right after, intervals are long
  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    grant[0] = 1'b0;
    grant[1] = 1'b0;
    case (state_ff)
      pattern_pkg::XS_IDLE: begin
        if (pend_ff[0]) begin
          nxt_state = pattern_pkg::XS_READ;
          nxt_chan = 1'b0;
          grant[0] = 1'b1;
        end else if (pend_ff[1]) begin
          nxt_state = pattern_pkg::XS_READ;
          nxt_chan = 1'b1;
          grant[1] = 1'b1;
        end
      end
      pattern_pkg::XS_READ: nxt_state = pattern_pkg::XS_WRITE;
      pattern_pkg::XS_WRITE: nxt_state = pattern_pkg::XS_IDLE;
      default: nxt_state = pattern_pkg::XS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff <= pattern_pkg::XS_IDLE;
      chan_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
    end
  end

  pattern_rom #(
    .AW(pattern_pkg::ROM_AW)
  ) u_rom (
    .clk(CLK),
    .srst(SRST),
    .addr(source_address_reg_ff[chan_ff][pattern_pkg::ROM_AW-1:0]),
    .rdata(rom_data)
  );

  assign last_xfer = (count_ff[chan_ff] == pattern_pkg::CNT_LAST);

  // descriptor write-back
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < 2; i++) begin
        source_address_reg_ff[i] <= SRC_BASE[i];
        count_ff[i] <= REPEAT[i];
      end
    end else if (state_ff == pattern_pkg::XS_WRITE) begin
      if (last_xfer) begin
        source_address_reg_ff[chan_ff] <= SRC_BASE[chan_ff];
        count_ff[chan_ff] <= REPEAT[chan_ff];
      end else begin
        source_address_reg_ff[chan_ff] <= source_address_reg_ff[chan_ff] + 1'b1;
        count_ff[chan_ff] <= count_ff[chan_ff] - 1'b1;
      end
    end
  end

  // destination is loaded once and never written back
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < 2; i++) begin
        dest_address_reg_ff[i] <= DEST[i];
      end
    end
  end

  // whole byte lands, so led low nibble is forced low by the table
  always_ff @(posedge CLK) begin
    if (SRST) begin
      led_port_ff <= pattern_pkg::LED_ALL_OFF;
      pattern_port_ff <= pattern_pkg::PAT_RESET;
    end else if (state_ff == pattern_pkg::XS_WRITE) begin
      if (dest_address_reg_ff[chan_ff] == pattern_pkg::LED_PORT_ADDR) begin
        led_port_ff <= rom_data;
      end
      if (dest_address_reg_ff[chan_ff] == pattern_pkg::PAT_PORT_ADDR) begin
        pattern_port_ff <= rom_data;
      end
    end
  end
  assign LED_PORT = led_port_ff;
  assign PATTERN_PINS = pattern_port_ff;

  // read port; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (SRST || !RD) begin
      rdata_ff <= 32'h0;
    end else begin
      case (ADDR)
        pattern_pkg::REG_CTRL: rdata_ff <= {30'h0, ctrl_ff};
        pattern_pkg::REG_STATUS: rdata_ff <= {21'h0,
          state_ff != pattern_pkg::XS_IDLE, pend_ff[1], pend_ff[0],
          count_ff[1], count_ff[0]};
        pattern_pkg::REG_SAR0: rdata_ff <= source_address_reg_ff[0];
        pattern_pkg::REG_SAR3: rdata_ff <= source_address_reg_ff[1];
        pattern_pkg::REG_DAR0: rdata_ff <= dest_address_reg_ff[0];
        pattern_pkg::REG_DAR3: rdata_ff <= dest_address_reg_ff[1];
        pattern_pkg::REG_PORTS: rdata_ff <= {16'h0, pattern_port_ff,
          led_port_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end
  assign RDATA = rdata_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_ch0_paced: assert property (match[0] |-> tick && ctrl_ff[0])
    else $error("channel 0 match off the prescaled tick");
  a_ch3_paced: assert property (match[1] |-> tick && ctrl_ff[1])
    else $error("channel 3 match off the prescaled tick");
  a_start_gates: assert property (!ctrl_ff[0] |-> !match[0])
    else $error("channel 0 matched while stopped");
  a_req_only: assert property (state_ff == pattern_pkg::XS_IDLE &&
    nxt_state == pattern_pkg::XS_READ |-> pend_ff[0] || pend_ff[1])
    else $error("transfer started with no request");
  a_src_fullwidth: assert property (
    source_address_reg_ff[0][31:4] == pattern_pkg::LED_SRC_BASE[31:4])
    else $error("source address left its table");
  a_src_step: assert property (state_ff == pattern_pkg::XS_WRITE &&
    !last_xfer |=> source_address_reg_ff[$past(chan_ff)] ==
    $past(source_address_reg_ff[chan_ff]) + 32'h1)
    else $error("source address did not increment");
  a_dest_fixed: assert property (dest_address_reg_ff[0] ==
    pattern_pkg::LED_PORT_ADDR && dest_address_reg_ff[1] ==
    pattern_pkg::PAT_PORT_ADDR)
    else $error("destination address changed");
  a_one_byte: assert property (state_ff == pattern_pkg::XS_READ |=>
    state_ff == pattern_pkg::XS_WRITE ##1 state_ff == pattern_pkg::XS_IDLE)
    else $error("transfer did not move exactly one byte");
  a_wrap_reload: assert property (state_ff == pattern_pkg::XS_WRITE &&
    last_xfer |=> count_ff[$past(chan_ff)] == REPEAT[$past(chan_ff)] &&
    source_address_reg_ff[$past(chan_ff)] == SRC_BASE[$past(chan_ff)])
    else $error("descriptor not reloaded at end of count");
  a_pat_first: assert property (state_ff == pattern_pkg::XS_READ &&
    chan_ff && source_address_reg_ff[1] == pattern_pkg::PAT_SRC_BASE
    |=> ##1 PATTERN_PINS == pattern_pkg::PAT_FIRST)
    else $error("first pattern byte wrong");
  a_led_low_zero: assert property (LED_PORT[3:0] == 4'h0)
    else $error("led port low nibble driven high");
  a_both_served: assert property (pend_ff[0] && pend_ff[1] &&
    state_ff == pattern_pkg::XS_IDLE |-> ##[1:6] state_ff ==
    pattern_pkg::XS_WRITE && chan_ff)
    else $error("second simultaneous request not served");

  a_ch3_gated: assert property (!ctrl_ff[1] |-> !match[1])
    else $error("channel 3 matched while stopped");
  a_src3_fullwidth: assert property (
    source_address_reg_ff[1][31:4] == pattern_pkg::PAT_SRC_BASE[31:4])
    else $error("channel 3 source address left its table");
  a_cnt0_range: assert property (count_ff[0] != 4'h0 &&
    count_ff[0] <= pattern_pkg::REPEAT0)
    else $error("channel 0 count out of range");
  a_cnt3_range: assert property (count_ff[1] != 4'h0 &&
    count_ff[1] <= pattern_pkg::REPEAT3)
    else $error("channel 3 count out of range");
  // a request must survive until its own grant, or a byte is lost
  a_pend0_held: assert property (pend_ff[0] && !grant[0] |=>
    pend_ff[0])
    else $error("channel 0 request dropped");
  a_pend3_held: assert property (pend_ff[1] && !grant[1] |=>
    pend_ff[1])
    else $error("channel 3 request dropped");
  a_led_write: assert property (state_ff == pattern_pkg::XS_WRITE &&
    !chan_ff |=> LED_PORT == $past(rom_data))
    else $error("led port missed its byte");
  a_pat_write: assert property (state_ff == pattern_pkg::XS_WRITE &&
    chan_ff |=> PATTERN_PINS == $past(rom_data))
    else $error("pattern port missed its byte");
  a_dest_route: assert property (state_ff == pattern_pkg::XS_WRITE &&
    chan_ff |=> LED_PORT == $past(LED_PORT))
    else $error("channel 3 transfer touched the led port");

  c_ch3_wrap: cover property (state_ff == pattern_pkg::XS_WRITE &&
    chan_ff && last_xfer);
  c_ch3_write: cover property (state_ff == pattern_pkg::XS_WRITE && chan_ff);
  c_ch0_wrap: cover property (state_ff == pattern_pkg::XS_WRITE &&
    !chan_ff && last_xfer);
  c_both_pend: cover property (pend_ff[0] && pend_ff[1]);
endmodule // timer_paced_pattern_transfer
`default_nettype wire

//--- testbench/port_watch.sv
`timescale 1ns/1ps
`default_nettype none
module port_watch (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] led_port,
  input wire logic [7:0] pattern_pins,
  output logic [3:0] led_on
);
  logic [7:0] led_ff;
  logic [7:0] pat_ff;
  int cyc_ff = 0;
  logic [7:0] led_q[$];
  logic [7:0] pat_q[$];
  int led_t[$];
  int pat_t[$];

  // leds sink current, so a low pin lights one
  assign led_on = ~led_port[7:4];
  // only value changes are visible here; table neighbours always differ
  always @(posedge clk) begin
    cyc_ff <= cyc_ff + 1;
    led_ff <= led_port;
    pat_ff <= pattern_pins;
    if (!srst && led_port !== led_ff) begin
      led_q.push_back(led_port);
      led_t.push_back(cyc_ff);
    end
    if (!srst && pattern_pins !== pat_ff) begin
      pat_q.push_back(pattern_pins);
      pat_t.push_back(cyc_ff);
    end
  end
endmodule // port_watch
`default_nettype wire

//--- testbench/timer_paced_pattern_transfer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_paced_pattern_transfer_tb;
  localparam int PS = 4;
  localparam int M0 = 4;
  localparam int M3 = 2;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic [7:0] LED_PORT;
  logic [7:0] PATTERN_PINS;
  logic [3:0] led_on;
  logic [31:0] d;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 CLK = ~CLK;

  timer_paced_pattern_transfer #(.PRESCALE(PS), .MATCH0_COUNT(M0),
    .MATCH3_COUNT(M3)) u_dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LED_PORT(LED_PORT),
    .PATTERN_PINS(PATTERN_PINS));
  port_watch u_watch (.clk(CLK), .srst(SRST), .led_port(LED_PORT),
    .pattern_pins(PATTERN_PINS), .led_on(led_on));

  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // run should need a few hundred cycles
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("[ERR] timeout expected finish seen hang");
      print_verdict;
    end
  end

  task automatic chk32(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask

  task automatic do_reset;
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (12) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    u_watch.led_q.delete();
    u_watch.pat_q.delete();
    u_watch.led_t.delete();
    u_watch.pat_t.delete();
  endtask

  task automatic t_idle_regs;
    chk32("led reset", 32'h0f0, {24'h0, LED_PORT});
    repeat (40) @(negedge CLK);
    chk32("no xfer", 32'h0, u_watch.led_q.size() + u_watch.pat_q.size());
    reg_rd(pattern_pkg::REG_DAR0, d);
    chk32("dar0", pattern_pkg::LED_PORT_ADDR, d);
    reg_rd(pattern_pkg::REG_SAR3, d);
    chk32("sar3", pattern_pkg::PAT_SRC_BASE, d);
    reg_wr(pattern_pkg::REG_DAR3, 32'h0);
    reg_rd(pattern_pkg::REG_DAR3, d);
    chk32("dar3 ro", pattern_pkg::PAT_PORT_ADDR, d);
    reg_rd(8'hfc, d);
    chk32("unmapped", 32'h0, d);
    reg_rd(pattern_pkg::REG_STATUS, d);
    chk32("status", {24'h0, pattern_pkg::REPEAT3, pattern_pkg::REPEAT0}, d);
    reg_rd(pattern_pkg::REG_PORTS, d);
    chk32("ports", {16'h0, pattern_pkg::PAT_RESET, pattern_pkg::LED_ALL_OFF}, d);
  endtask

  task automatic t_ch3_alone;
    int k;
    reg_wr(pattern_pkg::REG_CTRL, 32'h2);
    reg_rd(pattern_pkg::REG_CTRL, d);
    chk32("ctrl", 32'h2, d);
    for (k = 0; k < 300 && u_watch.pat_q.size() < 10; k++) @(negedge CLK);
    reg_wr(pattern_pkg::REG_CTRL, 32'h0);
    chk32("pat count", 32'd10, u_watch.pat_q.size());
    for (k = 0; k < 10 && k < u_watch.pat_q.size(); k++) begin
      chk32("pat byte", {24'h0, pattern_pkg::ROM_INIT[8 + k % 8]},
        {24'h0, u_watch.pat_q[k]});
      if (k > 0)
        chk32("ch3 gap", PS * M3, u_watch.pat_t[k] - u_watch.pat_t[k-1]);
    end
    chk32("led idle", 32'h0, u_watch.led_q.size());
    reg_rd(pattern_pkg::REG_SAR3, d);
    // ten bytes: one full wrap plus two
    chk32("sar3 wrap", pattern_pkg::PAT_SRC_BASE + 32'h2, d);
    reg_rd(pattern_pkg::REG_DAR3, d);
    chk32("dar3 fixed", pattern_pkg::PAT_PORT_ADDR, d);
  endtask

  task automatic t_both;
    int k;
    reg_wr(pattern_pkg::REG_CTRL, 32'h3);
    for (k = 0; k < 400 && u_watch.led_q.size() < 5; k++) @(negedge CLK);
    reg_wr(pattern_pkg::REG_CTRL, 32'h0);
    chk32("led count", 32'd5, u_watch.led_q.size());
    for (k = 0; k < 5 && k < u_watch.led_q.size(); k++) begin
      chk32("led byte", {24'h0, pattern_pkg::ROM_INIT[k % 4]},
        {24'h0, u_watch.led_q[k]});
      chk32("led low", 32'h0, {28'h0, u_watch.led_q[k][3:0]});
      if (k > 0)
        chk32("ch0 gap", PS * M0, u_watch.led_t[k] - u_watch.led_t[k-1]);
    end
    chk32("led0 lit", 32'h1, {28'h0, led_on});
    // matches coincide every second ch3 period; none may be lost
    chk32("pat kept", 32'h1, {31'h0, u_watch.pat_q.size() >= 9});
    for (k = 0; k < 9 && k < u_watch.pat_q.size(); k++)
      chk32("pat both", {24'h0, pattern_pkg::ROM_INIT[8 + k % 8]},
        {24'h0, u_watch.pat_q[k]});
    // five led bytes: one wrap of four plus one
    reg_rd(pattern_pkg::REG_SAR0, d);
    chk32("sar0 step", pattern_pkg::LED_SRC_BASE + 32'h1, d);
    reg_rd(pattern_pkg::REG_PORTS, d);
    chk32("ports both", {16'h0, pattern_pkg::ROM_INIT[9], pattern_pkg::LED0_ON}, d);
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    t_idle_regs();
    t_ch3_alone();
    do_reset();
    t_both();
    print_verdict;
  end
endmodule // timer_paced_pattern_transfer_tb
`default_nettype wire
